// ===== src/chan_cfg.sv
`default_nettype none
module chan_cfg
  import dds_ctrl_pkg::*;
(
  input  wire logic   i_sys_clk,  // System clock.
  input  wire logic   i_reset_n,  // Asynchronous reset, active low.
  chan_cfg_if.chan    cfg         // Write path and decoded settings.
);
  logic [23:0] cfn_q, cfn_d;
  logic [1:0]  shift_q, shift_d;
  logic        match_q, match_d;

  // Next channel function word and its decoded fields.
  always_comb begin
    cfn_d = cfg.wr ? cfg.wdata : cfn_q;
    case (cfn_d[CFN_SCL_MSB:CFN_SCL_LSB])
      SCL_FULL:    shift_d = SHIFT_FULL;
      SCL_HALF:    shift_d = SHIFT_HALF;
      SCL_QUARTER: shift_d = SHIFT_QUART;
      SCL_EIGHTH:  shift_d = SHIFT_EIGHTH;
      default:     shift_d = SHIFT_FULL;
    endcase
    // Equal latency only applies with no modulation and no sweep.
    match_d = cfn_d[CFN_MATCH]
            & (cfn_d[CFN_AFP_MSB:CFN_AFP_LSB] == AFP_NONE)
            & ~cfn_d[CFN_SWEEP];
  end

  // Register this channel's own copy of the settings.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfn_q   <= RST_CHAN_FN;
      shift_q <= SHIFT_FULL;
      match_q <= 1'b0;
    end else begin
      cfn_q   <= cfn_d;
      shift_q <= shift_d;
      match_q <= match_d;
    end
  end

  // Decoded settings back to the controller.
  assign cfg.cfn         = cfn_q;
  assign cfg.scale_shift = shift_q;
  assign cfg.match_eff   = match_q;
  assign cfg.sw_dac_pd   = cfn_q[CFN_DACPD];
  assign cfg.sw_dig_pd   = cfn_q[CFN_DIGPD];
endmodule
`default_nettype wire

// ===== src/chan_cfg_if.sv
`default_nettype none
interface chan_cfg_if;
  logic        wr;
  logic [23:0] wdata;
  logic [23:0] cfn;
  logic        sw_dac_pd;
  logic        sw_dig_pd;
  logic [1:0]  scale_shift;
  logic        match_eff;

  modport ctrl (output wr, wdata,
                input  cfn, sw_dac_pd, sw_dig_pd, scale_shift, match_eff);
  modport chan (input  wr, wdata,
                output cfn, sw_dac_pd, sw_dig_pd, scale_shift, match_eff);
endinterface
`default_nettype wire

// ===== src/dds_clock_scale_powerdown_ctrl.sv
`default_nettype none
// Functional notes
// - A set match bit in the channel function register equalises latency.
// - Latency matching only acts while the channel is in single-tone mode.
// - The multiplier factor is the five-bit field 22:18 of function reg one.
// - A factor from 4 to 20 enables the multiplier at that integer ratio.
// - A factor below 4 or above 20 bypasses the multiplier with ratio one.
// - A VCO gain bit picks the low or high range and resets to low.
// - The multiplier is shut down whenever it is bypassed.
// - The mode pin picks the input buffer when low, the crystal when high.
// - Channel bits 9:8 scale DAC current: 11 full, 01 half, 10 quarter, 00 eighth.
// - With the pin low, channel bits 7:6 power down that channel's parts.
// - Pin high with bit 6 clear gives fast-recovery power-down.
// - Pin high with bit 6 set gives full power-down of everything.
// - With the pin high, software power-down bits are ignored.
// - Every power-down bit requests low power when one.
// - Channel register writes go to every channel enabled in the select reg.
module dds_clock_scale_powerdown_ctrl
  import dds_ctrl_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  input  wire logic                       i_sys_clk,   // System clock.
  input  wire logic                       i_reset_n,   // Reset, active low.
  input  wire logic [ADDR_W-1:0]          i_addr,      // Register address.
  input  wire logic [DATA_W-1:0]          i_wdata,     // Write data.
  input  wire logic                       i_wr,        // Write strobe.
  input  wire logic                       i_rd,        // Read strobe.
  input  wire logic                       i_clk_mode_sel, // Clock mode pin.
  input  wire logic                       i_ext_powerdown_pin, // Ext PD.
  output logic [DATA_W-1:0]               o_rdata,     // Read data.
  output logic                            o_pll_en,    // Multiplier on.
  output logic [4:0]                      o_mul_factor, // Clock ratio.
  output logic                            o_vco_high,  // VCO high range.
  output logic                            o_osc_en,    // Crystal osc on.
  output logic                            o_clkin_pd,  // Clock input off.
  output logic                            o_dac_bias_pd, // DAC bias off.
  output logic [NUM_CH-1:0]               o_dac_pd,    // DAC digital off.
  output logic [NUM_CH-1:0]               o_dig_pd,    // Channel logic off.
  output logic [2*NUM_CH-1:0]             o_dac_shift, // Current shift.
  output logic [NUM_CH-1:0]               o_match_delay, // Equal latency.
  output logic                            o_lock_wait  // Lock interval.
);
  logic [DATA_W-1:0]      csel_q, csel_d;
  logic [DATA_W-1:0]      fr1_q, fr1_d;
  logic [DATA_W-1:0]      rdata_q, rdata_d;
  pwr_mode_t              pm_q, pm_d;
  logic                   vco_q, vco_d;
  logic                   clkpd_q, clkpd_d;
  logic                   bias_q, bias_d;
  logic [NUM_CH-1:0]      dacpd_q, dacpd_d;
  logic [NUM_CH-1:0]      digpd_q, digpd_d;
  logic [2*NUM_CH-1:0]    shift_q, shift_d;
  logic [NUM_CH-1:0]      match_q, match_d;

  logic [NUM_CH-1:0]      ch_en;
  logic [NUM_CH-1:0]      sw_dac;
  logic [NUM_CH-1:0]      sw_dig;
  logic [NUM_CH-1:0]      ch_match;
  logic [2*NUM_CH-1:0]    ch_shift;
  logic [DATA_W-1:0]      ch_cfn [NUM_CH];
  logic                   cfn_wr;
  logic                   full_pd;
  logic                   pll_en;
  logic [4:0]             mul_eff;
  logic                   osc_en;
  logic                   lock_wait;

  assign ch_en   = csel_q[CSEL_EN_LSB +: NUM_CH];
  assign cfn_wr  = i_wr && (i_addr == OFF_CHAN_FN);
  assign full_pd = (pm_q == PM_FULL);

  // One configuration slice per channel, written through the select mask.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      chan_cfg_if cif ();
      assign cif.wr     = cfn_wr & ch_en[g];
      assign cif.wdata  = i_wdata;
      assign ch_cfn[g]  = cif.cfn;
      assign sw_dac[g]  = cif.sw_dac_pd;
      assign sw_dig[g]  = cif.sw_dig_pd;
      assign ch_match[g] = cif.match_eff;
      assign ch_shift[2*g +: 2] = cif.scale_shift;
      chan_cfg u_chan (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .cfg       (cif.chan)
      );
    end
  endgenerate

  // Reference clock source, multiplier and lock interval.
  ref_clk_ctrl #(
    .LOCK_CNT (LOCK_CNT)
  ) u_refclk (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_mul_field (fr1_q[FR1_MUL_MSB:FR1_MUL_LSB]),
    .i_mode_sel  (i_clk_mode_sel),
    .i_full_pd   (full_pd),
    .o_pll_en    (pll_en),
    .o_mul_eff   (mul_eff),
    .o_osc_en    (osc_en),
    .o_lock_wait (lock_wait)
  );

  // Shared register writes.
  always_comb begin
    csel_d = csel_q;
    fr1_d  = fr1_q;
    if (i_wr && (i_addr == OFF_CHAN_SEL)) begin
      csel_d = i_wdata;
    end
    if (i_wr && (i_addr == OFF_FUNC_ONE)) begin
      fr1_d = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      csel_q <= RST_CHAN_SEL;
      fr1_q  <= RST_FUNC_ONE;
    end else begin
      csel_q <= csel_d;
      fr1_q  <= fr1_d;
    end
  end

  // Power mode follows the external pin and the full/fast select bit.
  always_comb begin
    case (pm_q)
      PM_RUN, PM_FAST, PM_FULL: begin
        if (!i_ext_powerdown_pin) begin
          pm_d = PM_RUN;
        end else if (fr1_q[FR1_FULLPD]) begin
          pm_d = PM_FULL;
        end else begin
          pm_d = PM_FAST;
        end
      end
      default: pm_d = PM_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pm_q <= PM_RUN;
    end else begin
      pm_q <= pm_d;
    end
  end

  // Power-down outputs: software bits only count in the run mode.
  always_comb begin
    vco_d   = fr1_q[FR1_VCO_BIT];
    bias_d  = (pm_q == PM_FULL);
    clkpd_d = (pm_q == PM_FULL)
            | ((pm_q == PM_RUN) & fr1_q[FR1_CLKPD]);
    for (int i = 0; i < NUM_CH; i++) begin
      if (pm_q == PM_RUN) begin
        dacpd_d[i] = sw_dac[i];
        digpd_d[i] = sw_dig[i];
      end else begin
        dacpd_d[i] = 1'b1;
        digpd_d[i] = 1'b1;
      end
    end
    shift_d = ch_shift;
    match_d = ch_match;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vco_q   <= 1'b0;
      bias_q  <= 1'b0;
      clkpd_q <= 1'b0;
      dacpd_q <= '0;
      digpd_q <= '0;
      shift_q <= '0;
      match_q <= '0;
    end else begin
      vco_q   <= vco_d;
      bias_q  <= bias_d;
      clkpd_q <= clkpd_d;
      dacpd_q <= dacpd_d;
      digpd_q <= digpd_d;
      shift_q <= shift_d;
      match_q <= match_d;
    end
  end

  // Read path: the channel register shows the lowest enabled channel.
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        OFF_CHAN_SEL: rdata_d = csel_q;
        OFF_FUNC_ONE: rdata_d = fr1_q;
        OFF_CHAN_FN: begin
          rdata_d = ch_cfn[0];
          for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (ch_en[i]) begin
              rdata_d = ch_cfn[i];
            end
          end
        end
        OFF_STATUS: begin
          rdata_d[ST_RUN]       = (pm_q == PM_RUN);
          rdata_d[ST_FAST]      = (pm_q == PM_FAST);
          rdata_d[ST_FULL]      = (pm_q == PM_FULL);
          rdata_d[ST_PLL_EN]    = pll_en;
          rdata_d[ST_OSC_EN]    = osc_en;
          rdata_d[ST_LOCK_WAIT] = lock_wait;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops.
  assign o_rdata       = rdata_q;
  assign o_pll_en      = pll_en;
  assign o_mul_factor  = mul_eff;
  assign o_vco_high    = vco_q;
  assign o_osc_en      = osc_en;
  assign o_clkin_pd    = clkpd_q;
  assign o_dac_bias_pd = bias_q;
  assign o_dac_pd      = dacpd_q;
  assign o_dig_pd      = digpd_q;
  assign o_dac_shift   = shift_q;
  assign o_match_delay = match_q;
  assign o_lock_wait   = lock_wait;
endmodule
`default_nettype wire

// ===== src/dds_ctrl_pkg.sv
`default_nettype none
package dds_ctrl_pkg;
  // Register bus geometry.
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 24;
  localparam int          NUM_CH       = 4;

  // Register offsets.
  localparam logic [7:0]  OFF_CHAN_SEL = 8'h00;
  localparam logic [7:0]  OFF_FUNC_ONE = 8'h01;
  localparam logic [7:0]  OFF_CHAN_FN  = 8'h03;
  localparam logic [7:0]  OFF_STATUS   = 8'h1E;

  // Channel select register fields.
  localparam int          CSEL_EN_LSB  = 4;

  // Function register one fields.
  localparam int          FR1_VCO_BIT  = 23;
  localparam int          FR1_MUL_MSB  = 22;
  localparam int          FR1_MUL_LSB  = 18;
  localparam int          FR1_CLKPD    = 7;
  localparam int          FR1_FULLPD   = 6;

  // Channel function register fields.
  localparam int          CFN_AFP_MSB  = 23;
  localparam int          CFN_AFP_LSB  = 22;
  localparam int          CFN_SWEEP    = 14;
  localparam int          CFN_SCL_MSB  = 9;
  localparam int          CFN_SCL_LSB  = 8;
  localparam int          CFN_DACPD    = 7;
  localparam int          CFN_DIGPD    = 6;
  localparam int          CFN_MATCH    = 5;

  // Status register fields.
  localparam int          ST_RUN       = 0;
  localparam int          ST_FAST      = 1;
  localparam int          ST_FULL      = 2;
  localparam int          ST_PLL_EN    = 3;
  localparam int          ST_OSC_EN    = 4;
  localparam int          ST_LOCK_WAIT = 5;

  // Reset values.
  localparam logic [23:0] RST_CHAN_SEL = 24'h0000F0;
  localparam logic [23:0] RST_FUNC_ONE = 24'h000000;
  localparam logic [23:0] RST_CHAN_FN  = 24'h000300;

  // Multiplier range and bypass factor.
  localparam logic [4:0]  MUL_MIN      = 5'h04;
  localparam logic [4:0]  MUL_MAX      = 5'h14;
  localparam logic [4:0]  MUL_BYPASS   = 5'h01;

  // Scale codes and the matching attenuation shift.
  localparam logic [1:0]  SCL_FULL     = 2'h3;
  localparam logic [1:0]  SCL_HALF     = 2'h1;
  localparam logic [1:0]  SCL_QUARTER  = 2'h2;
  localparam logic [1:0]  SCL_EIGHTH   = 2'h0;
  localparam logic [1:0]  SHIFT_FULL   = 2'h0;
  localparam logic [1:0]  SHIFT_HALF   = 2'h1;
  localparam logic [1:0]  SHIFT_QUART  = 2'h2;
  localparam logic [1:0]  SHIFT_EIGHTH = 2'h3;
  localparam logic [1:0]  AFP_NONE     = 2'h0;

  // Timing: clock rate and loop lock time.
  localparam int          CLK_MHZ      = 25;
  localparam int          LOCK_TIME_US = 1000;
  localparam int          LOCK_CYCLES  = CLK_MHZ * LOCK_TIME_US;

  // Power mode, one-hot.
  typedef enum logic [2:0] {
    PM_RUN  = 3'b001,
    PM_FAST = 3'b010,
    PM_FULL = 3'b100
  } pwr_mode_t;
endpackage
`default_nettype wire

// ===== src/ref_clk_ctrl.sv
`default_nettype none
module ref_clk_ctrl
  import dds_ctrl_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  input  wire logic       i_sys_clk,    // System clock.
  input  wire logic       i_reset_n,    // Asynchronous reset, active low.
  input  wire logic [4:0] i_mul_field,  // Raw multiplier field.
  input  wire logic       i_mode_sel,   // Clock mode select pin.
  input  wire logic       i_full_pd,    // Full power-down active.
  output logic            o_pll_en,     // Multiplier enabled.
  output logic [4:0]      o_mul_eff,    // Effective factor.
  output logic            o_osc_en,     // Crystal oscillator enabled.
  output logic            o_lock_wait   // Loop lock interval running.
);
  localparam int CW = $clog2(LOCK_CNT + 1);

  logic          pll_en_q, pll_en_d;
  logic [4:0]    mul_q, mul_d;
  logic          osc_q, osc_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          lock_q;
  logic          in_range;

  // Decode the factor, bypass, oscillator and lock interval.
  always_comb begin
    in_range = (i_mul_field >= MUL_MIN) && (i_mul_field <= MUL_MAX);
    pll_en_d = in_range & ~i_full_pd;
    mul_d    = in_range ? i_mul_field : MUL_BYPASS;
    osc_d    = i_mode_sel & ~i_full_pd;
    cnt_d    = cnt_q;
    // A fresh enable or new factor restarts the lock interval.
    if (pll_en_d && (!pll_en_q || (mul_d != mul_q))) begin
      cnt_d = CW'(LOCK_CNT);
    end else if (!pll_en_d) begin
      cnt_d = '0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Register the clock configuration.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pll_en_q <= 1'b0;
      mul_q    <= MUL_BYPASS;
      osc_q    <= 1'b0;
      cnt_q    <= '0;
      lock_q   <= 1'b0;
    end else begin
      pll_en_q <= pll_en_d;
      mul_q    <= mul_d;
      osc_q    <= osc_d;
      cnt_q    <= cnt_d;
      lock_q   <= (cnt_d != '0); // Registered so the output is a flop.
    end
  end

  assign o_pll_en    = pll_en_q;
  assign o_mul_eff   = mul_q;
  assign o_osc_en    = osc_q;
  assign o_lock_wait = lock_q;
endmodule
`default_nettype wire

// ===== test/dds_clock_scale_powerdown_ctrl_bench.sv
`default_nettype none
module dds_clock_scale_powerdown_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dds_ctrl_pkg::*;
  logic        clk, rst_n, wr, rd, pd_req, xtal_req, pd_pin, mode_pin;
  logic        pll_en, vco_hi, osc_en, clkin_pd, bias_pd, lock_wait;
  logic [7:0]  addr, shift;
  logic [23:0] wdata, rdata, d;
  logic [4:0]  mul;
  logic [3:0]  dac_pd, dig_pd, match, m;
  logic [31:0] seed, v;
  logic [23:0] cfn [4];
  int          failures, cmp_count, n, hi;

  dds_clock_scale_powerdown_ctrl #(.LOCK_CNT(8)) u_dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_clk_mode_sel(mode_pin),
    .i_ext_powerdown_pin(pd_pin), .o_rdata(rdata), .o_pll_en(pll_en),
    .o_mul_factor(mul), .o_vco_high(vco_hi), .o_osc_en(osc_en),
    .o_clkin_pd(clkin_pd), .o_dac_bias_pd(bias_pd), .o_dac_pd(dac_pd),
    .o_dig_pd(dig_pd), .o_dac_shift(shift), .o_match_delay(match),
    .o_lock_wait(lock_wait));

  ext_ctrl_model u_ext (.i_sys_clk(clk), .i_pd_req(pd_req),
    .i_xtal_req(xtal_req), .o_ext_powerdown_pin(pd_pin),
    .o_clk_mode_sel(mode_pin));

  // Repeatable xorshift source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected attenuation shift for a scale code.
  function automatic logic [1:0] shift_of(input logic [1:0] c);
    return c == 2'h3 ? 2'h0 : c == 2'h1 ? 2'h1 : c == 2'h2 ? 2'h2 : 2'h3;
  endfunction
  // Ratio 4..20 is kept, anything else bypasses to one.
  function automatic logic [4:0] mul_of(input logic [4:0] f);
    return (f >= 5'h04 && f <= 5'h14) ? f : 5'h01;
  endfunction
  // Matching needs the bit and single-tone operation.
  function automatic logic match_of(input logic [23:0] c);
    return c[5] && c[23:22] == 2'h0 && !c[14];
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [23:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, x);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    seed = 32'd50;
    {rst_n, wr, rd, pd_req, xtal_req} = '0;
    addr = '0;
    wdata = '0;
    for (int c = 0; c < 4; c++) cfn[c] = 24'h000300;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk(24'(mul), 24'h1);
    chk(24'(vco_hi), 24'h0);
    chk(24'(shift), 24'h0);
    rd_reg(OFF_CHAN_SEL, 24'h0000F0);
    rd_reg(OFF_FUNC_ONE, 24'h0);
    rd_reg(OFF_CHAN_FN, 24'h000300);
    rd_reg(8'h55, 24'h0);
    $display("test reset done");

    // Every multiplier code, with the range edges 3, 4, 20 and 21.
    for (int f = 0; f < 32; f++) begin
      v = xs();
      d = {v[23], 5'(f), v[17:8], 2'h0, v[5:0]};
      wr_reg(OFF_FUNC_ONE, d);
      settle(2);
      chk(24'(mul), 24'(mul_of(5'(f))));
      chk(24'(pll_en), 24'(f >= 4 && f <= 20));
      chk(24'(vco_hi), 24'(d[23]));
      if (f == 10) begin
        hi = 0;
        for (n = 0; n < 40 && lock_wait !== 1'b0; n++) begin
          hi++;
          @(posedge clk);
          #1;
        end
        chk(24'(hi != 0 && n < 40), 24'h1);
      end
    end
    rd_reg(OFF_FUNC_ONE, d);
    $display("test multiplier done");

    // Channel writes through random select masks.
    for (int r = 0; r < 12; r++) begin
      v = xs();
      m = r == 0 ? 4'h0 : r == 1 ? 4'hF : v[3:0];
      d = 24'(xs());
      if (v[31]) d[23:22] = 2'h0;
      if (v[30]) d[14] = 1'b0;
      if (r >= 2 && r < 6) d[9:8] = 2'(r);
      wr_reg(OFF_CHAN_SEL, {16'h0, m, 4'h0});
      wr_reg(OFF_CHAN_FN, d);
      for (int c = 0; c < 4; c++) if (m[c]) cfn[c] = d;
      settle(3);
      for (int c = 0; c < 4; c++) begin
        chk(24'(shift[2*c+:2]), 24'(shift_of(cfn[c][9:8])));
        chk(24'(match[c]), 24'(match_of(cfn[c])));
        chk(24'(dac_pd[c]), 24'(cfn[c][7]));
        chk(24'(dig_pd[c]), 24'(cfn[c][6]));
      end
      n = m[0] ? 0 : m[1] ? 1 : m[2] ? 2 : m[3] ? 3 : 0;
      rd_reg(OFF_CHAN_FN, cfn[n]);
    end
    $display("test channels done");

    // Pin power-down in fast and full forms, then software control.
    wr_reg(OFF_CHAN_SEL, 24'h0000F0);
    wr_reg(OFF_CHAN_FN, 24'h000380);
    for (int fd = 0; fd < 2; fd++) begin
      wr_reg(OFF_FUNC_ONE, {1'b0, 5'd10, 10'h0, 1'b1, 1'(fd), 6'h0});
      xtal_req <= 1'b1;
      pd_req <= 1'b1;
      settle(4);
      chk(24'(bias_pd), 24'(fd));
      chk(24'(clkin_pd), 24'(fd));
      chk(24'(osc_en), 24'(fd == 0));
      chk({16'h0, dac_pd, dig_pd}, 24'hFF);
      if (fd == 1) chk(24'(pll_en), 24'h0);
      if (fd == 1) rd_reg(OFF_STATUS, 24'h000004);
      pd_req <= 1'b0;
      settle(4);
      chk(24'(clkin_pd), 24'h1);
      chk(24'(bias_pd), 24'h0);
      chk({16'h0, dac_pd, dig_pd}, 24'hF0);
      chk(24'(osc_en), 24'h1);
      xtal_req <= 1'b0;
      settle(4);
      chk(24'(osc_en), 24'h0);
    end
    $display("test power-down done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== test/dds_ctrl_asserts.sv
`default_nettype none
module dds_ctrl_asserts
  import dds_ctrl_pkg::*;
(
  input wire logic              i_sys_clk,           // Clock.
  input wire logic              i_reset_n,           // Reset, low.
  input wire logic [ADDR_W-1:0] i_addr,              // Address.
  input wire logic              i_wr,                // Write strobe.
  input wire logic              i_rd,                // Read strobe.
  input wire logic              i_clk_mode_sel,      // Mode pin.
  input wire logic              i_ext_powerdown_pin, // PD pin.
  input wire logic [DATA_W-1:0] o_rdata,             // Read data.
  input wire logic              o_pll_en,            // Multiplier on.
  input wire logic [4:0]        o_mul_factor,        // Ratio.
  input wire logic              o_vco_high,          // VCO range.
  input wire logic              o_osc_en,            // Oscillator.
  input wire logic              o_clkin_pd,          // Clock input PD.
  input wire logic              o_dac_bias_pd,       // Bias PD.
  input wire logic [NUM_CH-1:0] o_dac_pd,            // DAC PD.
  input wire logic [NUM_CH-1:0] o_dig_pd,            // Logic PD.
  input wire logic              o_lock_wait          // Lock interval.
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the system clock and rest while reset is low.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_mul_legal: assert property (
    o_pll_en |-> o_mul_factor inside {[MUL_MIN:MUL_MAX]})
    else $error("multiplier on with illegal ratio");
  a_factor_set: assert property (
    o_mul_factor == MUL_BYPASS || o_mul_factor inside {[MUL_MIN:MUL_MAX]})
    else $error("ratio neither one nor in range");
  a_bypass_shut: assert property (
    o_mul_factor == MUL_BYPASS |-> !o_pll_en)
    else $error("multiplier left on while bypassed");
  a_full_all: assert property (
    o_dac_bias_pd |-> o_clkin_pd && !o_pll_en && !o_osc_en
                      && &o_dac_pd && &o_dig_pd)
    else $error("full power-down left a part running");
  a_pin_high_pd: assert property (
    i_ext_powerdown_pin [*3] |-> &o_dac_pd && &o_dig_pd)
    else $error("pin high but channel logic still on");
  a_pin_low_bias: assert property (
    !i_ext_powerdown_pin [*3] |-> !o_dac_bias_pd)
    else $error("bias off while pin low");
  a_osc_mode: assert property (
    (!i_ext_powerdown_pin && $stable(i_clk_mode_sel)) [*3]
      |-> o_osc_en == i_clk_mode_sel)
    else $error("oscillator does not follow mode pin");
  a_rd_idle: assert property (
    !$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read cycle");
  a_vco_write: assert property (
    $changed(o_vco_high) |->
      ($past(i_wr, 2) && $past(i_addr, 2) == OFF_FUNC_ONE) ||
      ($past(i_wr) && $past(i_addr) == OFF_FUNC_ONE))
    else $error("VCO range changed without write");

  // Main scenarios reached.
  c_full: cover property (o_dac_bias_pd);
  c_fast: cover property (o_dac_pd[0] && !o_dac_bias_pd && o_osc_en);
  c_pll: cover property (o_pll_en && o_lock_wait);
endmodule

bind dds_clock_scale_powerdown_ctrl dds_ctrl_asserts u_chk (
  .i_sys_clk, .i_reset_n, .i_addr, .i_wr, .i_rd, .i_clk_mode_sel,
  .i_ext_powerdown_pin, .o_rdata, .o_pll_en, .o_mul_factor, .o_vco_high,
  .o_osc_en, .o_clkin_pd, .o_dac_bias_pd, .o_dac_pd, .o_dig_pd,
  .o_lock_wait
);
`default_nettype wire

// ===== test/ext_ctrl_model.sv
`default_nettype none
module ext_ctrl_model (
  input  wire logic i_sys_clk,           // Clock.
  input  wire logic i_pd_req,            // Wanted power-down.
  input  wire logic i_xtal_req,          // Wanted crystal mode.
  output var logic  o_ext_powerdown_pin, // Power-down pin.
  output var logic  o_clk_mode_sel       // Clock mode pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins start powered up with the input buffer selected.
  initial begin
    o_ext_powerdown_pin = 1'b0;
    o_clk_mode_sel = 1'b0;
  end
  // The controller moves its pins just after a clock edge.
  always @(posedge i_sys_clk) begin
    o_ext_powerdown_pin <= i_pd_req;
    o_clk_mode_sel <= i_xtal_req;
  end
endmodule
`default_nettype wire
